// *** verilog/cis_consts.svh ***
// Summary of operation
// - jump loads 11-bit literal into pc low bits, no flags, two cycles
// - jump copies upper latch bits 4:3 into pc bits 12:11
// - decrement-skip stores file minus one per destination, skips on zero
// - decrement-skip takes one cycle, or two with a no-op on zero
// - increment adds one to file per destination, updates zero only
// - rotate right goes through carry, result per destination, carry only
// - power-down clears power-down flag and sets timeout flag
// - power-down clears watchdog counter and its prescaler
// - after power-down the core sleeps with oscillator halted
// - literal minus accumulator to accumulator, updates carry, digit carry, zero
// - subtraction sets carry when result zero or positive
// - negative subtraction clears carry, result wraps modulo 256
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH
`define CIS_OP_SLEEP 14'h0063
`define CIS_OP_SUB_ACC_FILE 6'h02
`define CIS_OP_INC_FILE 6'h0A
`define CIS_OP_DEC_SKIP 6'h0B
`define CIS_OP_ROT_RIGHT 6'h0C
`define CIS_OP_ROT_LEFT 6'h0D
`define CIS_OP_JMP 3'h5
`define CIS_OP_SUB_ACC_LIT 5'h1E
`define CIS_ADR_STATUS 7'h03
`define CIS_ADR_LATCH 7'h0A
`define CIS_ADR_WATCHDOG 7'h10
`define CIS_ADR_ACC 7'h11
`define CIS_ADR_PCLO 7'h12
`define CIS_ADR_PCHI 7'h13
`define CIS_ADR_CTRL 7'h14
`define CIS_ADR_INSN 7'h15
`define CIS_ADR_INSNHI 7'h16
`define CIS_ST_C 0
`define CIS_ST_DIGIT 1
`define CIS_ST_Z 2
`define CIS_ST_PWRDN 3
`define CIS_ST_TIMEOUT 4
`define CIS_STATUS_RST 8'h18
`define CIS_CTRL_WAKE 1
`define CIS_CTRL_EXEC 0
`define CIS_WATCHDOG_RST 8'h00
`define CIS_PRE_RST 8'h00
`define CIS_FILES 16
`endif

// *** verilog/cis_pkg.sv ***
package cis_pkg;
	typedef enum logic [2:0] {
		CIS_RUN = 3'h1,
		CIS_FLUSH = 3'h2,
		CIS_SLEEP = 3'h4
	} cis_state_t;
	typedef struct packed {
		logic [7:0] res;
		logic [7:0] status;
		logic we_file;
		logic we_acc;
		logic skip;
		logic jump;
		logic sleep;
	} cis_alu_t;
endpackage : cis_pkg

// *** verilog/cis_alu_if.sv ***
`timescale 1ns/1ps
interface cis_alu_if;
	logic [13:0] insn;
	logic [7:0] acc;
	logic [7:0] fval;
	logic [7:0] status;
	cis_pkg::cis_alu_t out;
	modport core (output insn, output acc, output fval, output status, input out);
	modport alu (input insn, input acc, input fval, input status, output out);
endinterface : cis_alu_if

// *** verilog/cis_alu.sv ***
`timescale 1ns/1ps
`include "cis_consts.svh"
module cis_alu (
	cis_alu_if.alu a
);
	logic [8:0] diff;
	logic [4:0] ldiff;
	logic [7:0] opnd;
	logic d;
	always_comb begin
		d = a.insn[7];
		opnd = (a.insn[13:9] == `CIS_OP_SUB_ACC_LIT) ? a.insn[7:0] : a.fval;
		diff = {1'b0, opnd} + {1'b0, ~a.acc} + 9'h001;
		ldiff = {1'b0, opnd[3:0]} + {1'b0, ~a.acc[3:0]} + 5'h01;
		a.out = '0;
		a.out.status = a.status;
		if (a.insn == `CIS_OP_SLEEP) begin
			a.out.sleep = 1'b1;
			a.out.status[`CIS_ST_PWRDN] = 1'b0;
			a.out.status[`CIS_ST_TIMEOUT] = 1'b1;
		end else if (a.insn[13:11] == `CIS_OP_JMP) begin
			a.out.jump = 1'b1;
		end else if (a.insn[13:9] == `CIS_OP_SUB_ACC_LIT) begin
			a.out.res = diff[7:0];
			a.out.we_acc = 1'b1;
			a.out.status[`CIS_ST_C] = diff[8];
			a.out.status[`CIS_ST_DIGIT] = ldiff[4];
			a.out.status[`CIS_ST_Z] = (diff[7:0] == 8'h00);
		end else if (a.insn[13:12] == 2'h0) begin
			a.out.we_file = d;
			a.out.we_acc = ~d;
			unique case (a.insn[13:8])
				`CIS_OP_SUB_ACC_FILE: begin
					a.out.res = diff[7:0];
					a.out.status[`CIS_ST_C] = diff[8];
					a.out.status[`CIS_ST_DIGIT] = ldiff[4];
					a.out.status[`CIS_ST_Z] = (diff[7:0] == 8'h00);
				end
				`CIS_OP_INC_FILE: begin
					a.out.res = a.fval + 8'h01;
					a.out.status[`CIS_ST_Z] = (a.out.res == 8'h00);
				end
				`CIS_OP_DEC_SKIP: begin
					a.out.res = a.fval - 8'h01;
					a.out.skip = (a.out.res == 8'h00);
				end
				`CIS_OP_ROT_RIGHT: begin
					a.out.res = {a.status[`CIS_ST_C], a.fval[7:1]};
					a.out.status[`CIS_ST_C] = a.fval[0];
				end
				`CIS_OP_ROT_LEFT: begin
					a.out.res = {a.fval[6:0], a.status[`CIS_ST_C]};
					a.out.status[`CIS_ST_C] = a.fval[7];
				end
				default: begin
					a.out.we_file = 1'b0;
					a.out.we_acc = 1'b0;
				end
			endcase
		end
	end
endmodule : cis_alu

// *** verilog/cis_regs.sv ***
`timescale 1ns/1ps
`include "cis_consts.svh"
module cis_regs #(
	parameter int DEPTH = `CIS_FILES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] ridx_i,
	output logic [7:0] rdata_o,
	input wire logic we_i,
	input wire logic [3:0] widx_i,
	input wire logic [7:0] wdata_i
);
	if (DEPTH != 16) begin : g_bad_depth
		$error("cis_regs depth must be 16");
	end
	typedef struct packed {
		logic [15:0][7:0] mem;
	} cis_mem_t;
	cis_mem_t mem_ff;
	cis_mem_t nxt_mem;
	always_comb begin
		nxt_mem = mem_ff;
		if (we_i) nxt_mem.mem[widx_i] = wdata_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) mem_ff <= '0;
		else mem_ff <= nxt_mem;
	end
	assign rdata_o = mem_ff.mem[ridx_i];
endmodule : cis_regs

// *** verilog/cis_core.sv ***
`timescale 1ns/1ps
`include "cis_consts.svh"
module cis_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic sleep_o,
	output logic osc_run_o
);
	typedef struct packed {
		cis_pkg::cis_state_t st;
		logic [12:0] pc;
		logic [7:0] acc;
		logic [7:0] status;
		logic [7:0] latch;
		logic [7:0] wdog_cnt;
		logic [7:0] pre;
		logic [13:0] insn;
		logic ack;
		logic [31:0] rdat;
	} cis_core_st_t;
	cis_core_st_t s_ff;
	cis_core_st_t nxt_s;
	cis_alu_if alu_bus ();
	logic [7:0] fval;
	logic file_we;
	logic [7:0] file_wd;
	logic [3:0] file_wi;
	logic bus_wr;
	logic bus_rd;
	logic exec;
	logic [6:0] fadr;
	logic [6:0] badr;
	logic [3:0] bidx;
	logic [7:0] bval;
	logic [7:0] gpr_rd;
	logic [3:0] ridx;
	logic bus_gpr;
	assign fadr = s_ff.insn[6:0];
	assign badr = wb_adr_i[8:2];
	assign bidx = badr[3:0];
	assign bus_gpr = (badr >= 7'h20) && (badr < 7'h30);
	// a write lands at the edge where the master sees ack
	assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & s_ff.ack;
	assign bus_rd = wb_cyc_i & wb_stb_i & ~s_ff.ack;
	assign exec = bus_wr & (badr == `CIS_ADR_CTRL) & wb_dat_i[`CIS_CTRL_EXEC]
		& (s_ff.st == cis_pkg::CIS_RUN);
	function automatic logic [7:0] sfr(input logic [6:0] ad);
		logic [7:0] v;
		v = 8'h00;
		unique case (ad)
			`CIS_ADR_STATUS: v = s_ff.status;
			`CIS_ADR_LATCH: v = s_ff.latch;
			`CIS_ADR_WATCHDOG: v = s_ff.wdog_cnt;
			`CIS_ADR_ACC: v = s_ff.acc;
			`CIS_ADR_PCLO: v = s_ff.pc[7:0];
			`CIS_ADR_PCHI: v = {3'h0, s_ff.pc[12:8]};
			`CIS_ADR_INSN: v = s_ff.insn[7:0];
			`CIS_ADR_INSNHI: v = {2'h0, s_ff.insn[13:8]};
			`CIS_ADR_CTRL: v = {5'h00, s_ff.st};
			default: v = 8'h00;
		endcase
		return v;
	endfunction : sfr
	logic is_sfr_f;
	assign is_sfr_f = !((fadr >= 7'h20) && (fadr < 7'h30));
	// a bus read of a general file owns the read port, else the operand does
	assign ridx = (wb_cyc_i && wb_stb_i && !wb_we_i && bus_gpr) ? bidx : fadr[3:0];
	cis_regs #(.DEPTH(`CIS_FILES)) u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ridx_i(ridx),
		.rdata_o(gpr_rd),
		.we_i(file_we),
		.widx_i(file_wi),
		.wdata_i(file_wd)
	);
	always_comb begin
		fval = is_sfr_f ? sfr(fadr) : gpr_rd;
		bval = bus_gpr ? gpr_rd : sfr(badr);
	end
	assign alu_bus.insn = s_ff.insn;
	assign alu_bus.acc = s_ff.acc;
	assign alu_bus.fval = fval;
	assign alu_bus.status = s_ff.status;
	cis_alu u_alu (
		.a(alu_bus.alu)
	);
	always_comb begin
		file_we = 1'b0;
		file_wi = fadr[3:0];
		file_wd = alu_bus.out.res;
		if (exec && alu_bus.out.we_file && !is_sfr_f) begin
			file_we = 1'b1;
		end else if (bus_wr && badr >= 7'h20 && badr < 7'h30) begin
			file_we = 1'b1;
			file_wi = bidx;
			file_wd = wb_dat_i[7:0];
		end
	end
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ack = bus_rd;
		nxt_s.rdat = {24'h000000, bval};
		nxt_s.pre = s_ff.pre + 8'h01;
		if (s_ff.pre == 8'hFF) nxt_s.wdog_cnt = s_ff.wdog_cnt + 8'h01;
		if (bus_wr) begin
			unique case (badr)
				`CIS_ADR_LATCH: nxt_s.latch = wb_dat_i[7:0];
				`CIS_ADR_ACC: nxt_s.acc = wb_dat_i[7:0];
				`CIS_ADR_STATUS: nxt_s.status = wb_dat_i[7:0];
				`CIS_ADR_INSN: nxt_s.insn[7:0] = wb_dat_i[7:0];
				`CIS_ADR_INSNHI: nxt_s.insn[13:8] = wb_dat_i[5:0];
				`CIS_ADR_CTRL: if (wb_dat_i[`CIS_CTRL_WAKE] && s_ff.st == cis_pkg::CIS_SLEEP)
					nxt_s.st = cis_pkg::CIS_RUN;
				default: ;
			endcase
		end
		unique case (s_ff.st)
			cis_pkg::CIS_RUN: if (exec) begin
				nxt_s.status = alu_bus.out.status;
				nxt_s.pc = s_ff.pc + 13'h0001;
				if (alu_bus.out.we_acc) nxt_s.acc = alu_bus.out.res;
				if (alu_bus.out.we_file && is_sfr_f) begin
					if (fadr == `CIS_ADR_STATUS) nxt_s.status = alu_bus.out.res;
					if (fadr == `CIS_ADR_LATCH) nxt_s.latch = alu_bus.out.res;
				end
				if (alu_bus.out.jump) begin
					nxt_s.pc = {s_ff.latch[4:3], s_ff.insn[10:0]};
					nxt_s.st = cis_pkg::CIS_FLUSH;
				end
				if (alu_bus.out.skip) begin
					nxt_s.pc = s_ff.pc + 13'h0002;
					nxt_s.st = cis_pkg::CIS_FLUSH;
				end
				if (alu_bus.out.sleep) begin
					nxt_s.wdog_cnt = `CIS_WATCHDOG_RST;
					nxt_s.pre = `CIS_PRE_RST;
					nxt_s.st = cis_pkg::CIS_SLEEP;
				end
			end
			cis_pkg::CIS_FLUSH: nxt_s.st = cis_pkg::CIS_RUN;
			cis_pkg::CIS_SLEEP: begin
				nxt_s.pre = s_ff.pre;
				nxt_s.wdog_cnt = s_ff.wdog_cnt;
			end
			default: nxt_s.st = cis_pkg::CIS_RUN;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff <= '0;
			s_ff.st <= cis_pkg::CIS_RUN;
			s_ff.status <= `CIS_STATUS_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign wb_ack_o = s_ff.ack;
	assign wb_dat_o = s_ff.rdat;
	assign sleep_o = (s_ff.st == cis_pkg::CIS_SLEEP);
	assign osc_run_o = (s_ff.st != cis_pkg::CIS_SLEEP);

	sequence s_jump;
		exec && alu_bus.out.jump;
	endsequence
	a_jump_target: assert property (@(posedge clk_i) disable iff (rst_i)
		s_jump |=> s_ff.pc == {$past(s_ff.latch[4:3]), $past(s_ff.insn[10:0])})
		else $error("jump target wrong");
	a_jump_two_cyc: assert property (@(posedge clk_i) disable iff (rst_i)
		s_jump |=> s_ff.st == cis_pkg::CIS_FLUSH ##1 s_ff.st == cis_pkg::CIS_RUN)
		else $error("jump not two cycles");
	a_jump_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && alu_bus.out.jump && !(bus_wr && badr == `CIS_ADR_STATUS)
		|=> $stable(s_ff.status))
		else $error("jump changed flags");
	a_skip_flush: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn[13:8] == `CIS_OP_DEC_SKIP && fval == 8'h01
		|=> s_ff.st == cis_pkg::CIS_FLUSH)
		else $error("skip missing");
	a_noskip_run: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn[13:8] == `CIS_OP_DEC_SKIP && fval != 8'h01
		|=> s_ff.st == cis_pkg::CIS_RUN)
		else $error("spurious skip");
	a_sleep_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn == `CIS_OP_SLEEP
		|=> !s_ff.status[`CIS_ST_PWRDN] && s_ff.status[`CIS_ST_TIMEOUT])
		else $error("sleep flags wrong");
	a_sleep_wdt: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn == `CIS_OP_SLEEP |=> s_ff.wdog_cnt == 8'h00 && s_ff.pre == 8'h00)
		else $error("watchdog not cleared");
	a_sleep_osc: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn == `CIS_OP_SLEEP |=> sleep_o && !osc_run_o)
		else $error("no sleep");
	a_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn[13:9] == `CIS_OP_SUB_ACC_LIT
		|=> s_ff.status[`CIS_ST_C] == ($past(s_ff.insn[7:0]) >= $past(s_ff.acc)))
		else $error("subtract carry wrong");
	a_lit_sub_res: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn[13:9] == `CIS_OP_SUB_ACC_LIT
		|=> s_ff.acc == $past(s_ff.insn[7:0]) - $past(s_ff.acc))
		else $error("literal subtract result wrong");
	a_file_sub_res: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn[13:7] == {`CIS_OP_SUB_ACC_FILE, 1'b0}
		|=> s_ff.acc == $past(fval) - $past(s_ff.acc))
		else $error("file subtract result wrong");
	a_incr_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && s_ff.insn[13:8] == `CIS_OP_INC_FILE && fadr != `CIS_ADR_STATUS
		|=> s_ff.status[`CIS_ST_Z] == ($past(fval) == 8'hFF))
		else $error("increment zero flag wrong");
endmodule : cis_core

// *** sim/cpu_instruction_subset_exec_tb_top.sv ***
`timescale 1ns/1ps
`include "cis_consts.svh"
module cpu_instruction_subset_exec_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_ack_o;
	logic sleep_o;
	logic osc_run_o;
	int bad_count = 0;
	int num_checks = 0;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [7:0] me, mm, acc, fv, k, st;
	logic [31:0] seed = 32'h07AA;
	logic [12:0] pc = 13'h0;
	logic [15:0] sr;
	logic c, cn;
	always #12.5 clk_i = ~clk_i;
	cis_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_o(sleep_o), .osc_run_o(osc_run_o));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// result and flags of x minus y: {status, result}
	function automatic logic [15:0] subf(input logic [7:0] x, input logic [7:0] y);
		logic [7:0] r;
		r = x - y;
		return {5'h0, r == 8'h00, x[3:0] >= y[3:0], x >= y, r};
	endfunction : subf
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic bus(input logic [6:0] idx, input logic we, input logic [7:0] d,
		input logic [3:0] sel);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {23'h0, idx, 2'h0};
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("FAIL %0t no ack", $time);
			tally_and_finish();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d, 4'hF);
	endtask : wr
	task automatic rd(input logic [6:0] idx, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(idx, 1'b0, 8'h00, 4'hF);
	endtask : rd
	task automatic ex(input logic [13:0] i);
		wr(`CIS_ADR_INSN, i[7:0]);
		wr(`CIS_ADR_INSNHI, {2'h0, i[13:8]});
		wr(`CIS_ADR_CTRL, 8'h01);
		pc = pc + 13'h1;
	endtask : ex
	task automatic chk(input logic got, input logic e);
		num_checks++;
		if (got !== e) begin
			bad_count++;
			$display("FAIL %0t pin level", $time);
		end
	endtask : chk
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			num_checks++;
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("FAIL %0t unexpected read", $time);
			end else begin
				me = exp_q.pop_front();
				mm = msk_q.pop_front();
				if ((wb_dat_o & {24'hFFFFFF, mm}) !== {24'h0, me & mm}) begin
					bad_count++;
					$display("FAIL %0t read %h expected %h", $time, wb_dat_o, me);
				end
			end
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`CIS_ADR_STATUS, `CIS_STATUS_RST, 8'hFF);
		rd(`CIS_ADR_CTRL, 8'h01, 8'hFF);
		rd(7'h7F, 8'h00, 8'hFF);
		wr(`CIS_ADR_ACC, 8'h5A);
		bus(`CIS_ADR_ACC, 1'b1, 8'hA5, 4'hE);
		rd(`CIS_ADR_ACC, 8'h5A, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			acc = seed[7:0];
			fv = seed[15:8];
			c = seed[16];
			wr(`CIS_ADR_STATUS, {7'h0, c});
			wr(`CIS_ADR_ACC, acc);
			wr(7'h20, fv);
			ex({`CIS_OP_ROT_RIGHT, 1'b1, 7'h20});
			cn = fv[0];
			fv = {c, fv[7:1]};
			c = cn;
			rd(7'h20, fv, 8'hFF);
			rd(`CIS_ADR_STATUS, {7'h0, c}, 8'h01);
			ex({`CIS_OP_ROT_LEFT, 1'b0, 7'h20});
			acc = {fv[6:0], c};
			c = fv[7];
			rd(`CIS_ADR_ACC, acc, 8'hFF);
			rd(`CIS_ADR_STATUS, {7'h0, c}, 8'h01);
			ex({`CIS_OP_INC_FILE, 1'b1, 7'h20});
			fv = fv + 8'h01;
			rd(7'h20, fv, 8'hFF);
			rd(`CIS_ADR_STATUS, {5'h0, fv == 8'h00, 2'h0}, 8'h04);
			ex({`CIS_OP_SUB_ACC_FILE, 1'b0, 7'h20});
			sr = subf(fv, acc);
			acc = sr[7:0];
			rd(`CIS_ADR_ACC, acc, 8'hFF);
			rd(`CIS_ADR_STATUS, sr[15:8], 8'h07);
			k = (i == 0) ? acc : (i == 1) ? acc + 8'h01 : seed[31:24];
			ex({`CIS_OP_SUB_ACC_LIT, 1'b0, k});
			sr = subf(k, acc);
			acc = sr[7:0];
			st = sr[15:8];
			rd(`CIS_ADR_ACC, acc, 8'hFF);
			rd(`CIS_ADR_STATUS, st, 8'h07);
		end
		wr(7'h21, 8'h01);
		ex({`CIS_OP_DEC_SKIP, 1'b1, 7'h21});
		pc = pc + 13'h1;
		rd(7'h21, 8'h00, 8'hFF);
		rd(`CIS_ADR_PCLO, pc[7:0], 8'hFF);
		ex({`CIS_OP_DEC_SKIP, 1'b1, 7'h21});
		rd(7'h21, 8'hFF, 8'hFF);
		rd(`CIS_ADR_PCLO, pc[7:0], 8'hFF);
		wr(7'h21, 8'h02);
		ex({`CIS_OP_DEC_SKIP, 1'b0, 7'h21});
		rd(`CIS_ADR_ACC, 8'h01, 8'hFF);
		rd(7'h21, 8'h02, 8'hFF);
		rd(7'h20, fv, 8'hFF);
		for (int j = 0; j < 4; j++) begin
			seed = lfsr(seed);
			wr(`CIS_ADR_LATCH, {seed[7:5], j[1:0], seed[2:0]});
			ex({`CIS_OP_JMP, seed[18:8]});
			pc = {j[1:0], seed[18:8]};
			rd(`CIS_ADR_PCLO, pc[7:0], 8'hFF);
			rd(`CIS_ADR_PCHI, {3'h0, pc[12:8]}, 8'hFF);
			rd(`CIS_ADR_STATUS, st, 8'h07);
		end
		repeat (600) @(posedge clk_i);
		ex(`CIS_OP_SLEEP);
		@(posedge clk_i);
		#1;
		chk(sleep_o, 1'b1);
		chk(osc_run_o, 1'b0);
		rd(`CIS_ADR_STATUS, 8'h10, 8'h18);
		rd(`CIS_ADR_WATCHDOG, `CIS_WATCHDOG_RST, 8'hFF);
		rd(`CIS_ADR_CTRL, 8'h04, 8'hFF);
		wr(`CIS_ADR_CTRL, 8'h02);
		@(posedge clk_i);
		#1;
		chk(sleep_o, 1'b0);
		chk(osc_run_o, 1'b1);
		rd(`CIS_ADR_WATCHDOG, `CIS_WATCHDOG_RST, 8'hFF);
		repeat (3) @(posedge clk_i);
		num_checks++;
		if (exp_q.size() != 0) begin
			bad_count++;
			$display("FAIL %0t reads left unanswered", $time);
		end
		tally_and_finish();
	end
endmodule : cpu_instruction_subset_exec_tb_top
